/* hw/frie_pkg.sv */
// Package for the file register instruction execution block
package frie_pkg;

  // Instruction word widths, program counter width and return stack size
  localparam int unsigned FRIE_ADDR_W = 7;
  localparam int unsigned FRIE_DATA_W = 8;
  localparam int unsigned FRIE_PC_W = 15;
  localparam int unsigned FRIE_LATCH_W = 7;
  localparam int unsigned FRIE_STACK_DEPTH = 16;
  localparam int unsigned FRIE_STACK_PTR_W = 4;

  // Opcode encodings of this group (designer chosen)
  typedef enum logic [2:0] {
    FRIE_OP_NONE = 3'b000,
    FRIE_OP_WDT_CLEAR = 3'b001,
    FRIE_OP_CALL_ACC = 3'b010,
    FRIE_OP_COMPLEMENT = 3'b011,
    FRIE_OP_CLEAR_FILE = 3'b100,
    FRIE_OP_CLEAR_ACC = 3'b101,
    FRIE_OP_DECREMENT = 3'b110,
    FRIE_OP_DEC_SKIP = 3'b111
  } frie_op_t;

  // Decoded instruction as carried into the executer
  typedef struct packed {
    frie_op_t op;
    logic dest_file;
    logic [FRIE_ADDR_W-1:0] addr;
  } frie_instr_t;

  // Register bus offsets
  localparam logic [11:0] FRIE_OFF_CTRL = 12'h000;
  localparam logic [11:0] FRIE_OFF_ACC = 12'h004;
  localparam logic [11:0] FRIE_OFF_LATCH = 12'h008;
  localparam logic [11:0] FRIE_OFF_STATUS = 12'h00C;
  localparam logic [11:0] FRIE_OFF_PC = 12'h010;
  localparam logic [11:0] FRIE_OFF_FILE = 12'h014;
  localparam logic [11:0] FRIE_OFF_WDT = 12'h018;
  localparam logic [11:0] FRIE_OFF_STACK = 12'h01C;

  // Ctrl register fields
  localparam int unsigned FRIE_CTRL_ADDR_LSB = 0;
  localparam int unsigned FRIE_CTRL_DEST_BIT = 7;
  localparam int unsigned FRIE_CTRL_OP_LSB = 8;
  localparam int unsigned FRIE_CTRL_GO_BIT = 31;
  localparam int unsigned FRIE_CTRL_OP_W = 3;

  // File write word fields
  localparam int unsigned FRIE_FILE_ADDR_LSB = 8;

  // Status register fields
  localparam int unsigned FRIE_ST_ZERO_BIT = 0;
  localparam int unsigned FRIE_ST_SLEEP_N_BIT = 1;
  localparam int unsigned FRIE_ST_TIMEOUT_N_BIT = 2;
  localparam int unsigned FRIE_ST_BUSY_BIT = 3;
  localparam int unsigned FRIE_ST_SKIP_BIT = 4;

  // Watchdog sizes
  localparam int unsigned FRIE_WDT_W = 16;
  localparam int unsigned FRIE_PRESC_W = 8;

  // Reset values and step constants
  localparam logic [FRIE_PC_W-1:0] FRIE_PC_RESET = 15'h0000;
  localparam logic [FRIE_DATA_W-1:0] FRIE_DATA_ZERO = 8'h00;
  localparam logic [FRIE_DATA_W-1:0] FRIE_DATA_ONE = 8'h01;
  localparam logic [FRIE_PC_W-1:0] FRIE_PC_ONE = 15'h0001;
  localparam logic [31:0] FRIE_BUS_ZERO = 32'h0000_0000;

endpackage

/* hw/frie_file_ram.sv */
// Addressed file register array with one read and one write port
`timescale 1ns/1ps
module frie_file_ram #(
  parameter int unsigned ADDR_W = 7,
  parameter int unsigned DATA_W = 8
) (
  // Clock
  input wire logic i_sys_clk,
  // Write port
  input wire logic i_wr_en,
  input wire logic [ADDR_W-1:0] i_wr_addr,
  input wire logic [DATA_W-1:0] i_wr_data,
  // Read port
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [DATA_W-1:0] o_rd_data
);

  logic [DATA_W-1:0] mem [2**ADDR_W];

  // Synchronous write
  always_ff @(posedge i_sys_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // Asynchronous read
  assign o_rd_data = mem[i_rd_addr];

endmodule // frie_file_ram

/* hw/frie_exec.sv */
// Executer for the watchdog, call, clear, complement and decrement group
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module frie_exec (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Core state
  output logic [frie_pkg::FRIE_PC_W-1:0] o_program_counter,
  output logic o_timeout_flag_n,
  output logic o_sleep_flag_n,
  output logic o_busy
);

  typedef enum logic [1:0] {
    FRIE_ST_IDLE = 2'b00,
    FRIE_ST_EXEC = 2'b01,
    FRIE_ST_SECOND = 2'b10
  } frie_state_t;

  frie_state_t state_reg;
  frie_pkg::frie_instr_t instr_reg;
  logic [frie_pkg::FRIE_DATA_W-1:0] acc_reg;
  logic [frie_pkg::FRIE_LATCH_W-1:0] upper_pc_latch_reg;
  logic [frie_pkg::FRIE_PC_W-1:0] pc_reg;
  logic zero_reg;
  logic timeout_n_reg;
  logic sleep_n_reg;
  logic skip_reg;
  logic [frie_pkg::FRIE_WDT_W-1:0] watchdog_counter_reg;
  logic [frie_pkg::FRIE_PRESC_W-1:0] presc_reg;
  logic [frie_pkg::FRIE_PC_W-1:0] stack_mem [frie_pkg::FRIE_STACK_DEPTH];
  logic [frie_pkg::FRIE_STACK_PTR_W-1:0] sp_reg;
  logic [frie_pkg::FRIE_PC_W-1:0] stack_top_entry;
  logic [31:0] rdata_reg;
  logic ready_reg;
  logic [frie_pkg::FRIE_DATA_W-1:0] file_rd;
  logic [frie_pkg::FRIE_DATA_W-1:0] result;
  logic result_valid;
  logic file_wr_en;
  logic [frie_pkg::FRIE_DATA_W-1:0] file_wr_data;
  logic [frie_pkg::FRIE_ADDR_W-1:0] file_wr_addr;
  logic bus_wr;
  logic bus_setup;
  logic exec_now;
  logic go_write;

  // Bus qualifiers
  assign bus_setup = i_psel && !i_penable;
  assign bus_wr = i_psel && i_penable && ready_reg && i_pwrite;
  assign go_write = bus_wr && (i_paddr == frie_pkg::FRIE_OFF_CTRL)
    && i_pwdata[frie_pkg::FRIE_CTRL_GO_BIT] && (state_reg == FRIE_ST_IDLE);
  assign exec_now = (state_reg == FRIE_ST_EXEC);
  assign stack_top_entry = stack_mem[sp_reg - 1'b1];

  // Result of the operand path
  always_comb begin
    result = frie_pkg::FRIE_DATA_ZERO;
    result_valid = 1'b0;
    unique case (instr_reg.op)
      frie_pkg::FRIE_OP_COMPLEMENT: begin
        result = ~file_rd;
        result_valid = 1'b1;
      end
      frie_pkg::FRIE_OP_DECREMENT,
      frie_pkg::FRIE_OP_DEC_SKIP: begin
        result = file_rd - frie_pkg::FRIE_DATA_ONE;
        result_valid = 1'b1;
      end
      default: begin
        result = frie_pkg::FRIE_DATA_ZERO;
        result_valid = 1'b0;
      end
    endcase
  end

  // File write: execution has priority over software
  always_comb begin
    file_wr_en = 1'b0;
    file_wr_addr = instr_reg.addr;
    file_wr_data = result;
    if (exec_now && instr_reg.op == frie_pkg::FRIE_OP_CLEAR_FILE) begin
      file_wr_en = 1'b1;
      file_wr_data = frie_pkg::FRIE_DATA_ZERO;
    end else if (exec_now && result_valid && instr_reg.dest_file) begin
      file_wr_en = 1'b1;
    end else if (bus_wr && i_paddr == frie_pkg::FRIE_OFF_FILE) begin
      file_wr_en = 1'b1;
      file_wr_addr = i_pwdata[frie_pkg::FRIE_FILE_ADDR_LSB +:
        frie_pkg::FRIE_ADDR_W];
      file_wr_data = i_pwdata[frie_pkg::FRIE_DATA_W-1:0];
    end
  end

  frie_file_ram #(
    .ADDR_W(frie_pkg::FRIE_ADDR_W),
    .DATA_W(frie_pkg::FRIE_DATA_W)
  ) u_file (
    .i_sys_clk(i_sys_clk),
    .i_wr_en(file_wr_en),
    .i_wr_addr(file_wr_addr),
    .i_wr_data(file_wr_data),
    .i_rd_addr(instr_reg.addr),
    .o_rd_data(file_rd)
  );

  // Sequencer
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= FRIE_ST_IDLE;
    end else begin
      unique case (state_reg)
        FRIE_ST_IDLE: begin
          if (go_write) begin
            state_reg <= FRIE_ST_EXEC;
          end
        end
        FRIE_ST_EXEC: begin
          if (instr_reg.op == frie_pkg::FRIE_OP_CALL_ACC) begin
            state_reg <= FRIE_ST_SECOND;
          end else if (instr_reg.op == frie_pkg::FRIE_OP_DEC_SKIP
              && result == frie_pkg::FRIE_DATA_ZERO) begin
            state_reg <= FRIE_ST_SECOND;
          end else begin
            state_reg <= FRIE_ST_IDLE;
          end
        end
        FRIE_ST_SECOND: begin
          state_reg <= FRIE_ST_IDLE;
        end
        default: begin
          state_reg <= FRIE_ST_IDLE;
        end
      endcase
    end
  end

  // Instruction capture
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      instr_reg <= '0;
    end else if (go_write) begin
      // Seven bit address, one bit select
      instr_reg.addr <= i_pwdata[frie_pkg::FRIE_CTRL_ADDR_LSB +:
        frie_pkg::FRIE_ADDR_W];
      instr_reg.dest_file <= i_pwdata[frie_pkg::FRIE_CTRL_DEST_BIT];
      instr_reg.op <= frie_pkg::frie_op_t'(
        i_pwdata[frie_pkg::FRIE_CTRL_OP_LSB +: frie_pkg::FRIE_CTRL_OP_W]);
    end
  end

  // Accumulator
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc_reg <= frie_pkg::FRIE_DATA_ZERO;
    end else if (exec_now && instr_reg.op == frie_pkg::FRIE_OP_CLEAR_ACC) begin
      acc_reg <= frie_pkg::FRIE_DATA_ZERO;
    end else if (exec_now && result_valid && !instr_reg.dest_file) begin
      acc_reg <= result;
    end else if (bus_wr && i_paddr == frie_pkg::FRIE_OFF_ACC) begin
      acc_reg <= i_pwdata[frie_pkg::FRIE_DATA_W-1:0];
    end
  end

  // Upper latch
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      upper_pc_latch_reg <= '0;
    end else if (bus_wr && i_paddr == frie_pkg::FRIE_OFF_LATCH) begin
      upper_pc_latch_reg <= i_pwdata[frie_pkg::FRIE_LATCH_W-1:0];
    end
  end

  // Program counter
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pc_reg <= frie_pkg::FRIE_PC_RESET;
    end else if (exec_now && instr_reg.op == frie_pkg::FRIE_OP_CALL_ACC) begin
      pc_reg <= {upper_pc_latch_reg, acc_reg};
    end else if (exec_now) begin
      pc_reg <= pc_reg + frie_pkg::FRIE_PC_ONE;
    end else if (state_reg == FRIE_ST_SECOND && skip_reg) begin
      pc_reg <= pc_reg + frie_pkg::FRIE_PC_ONE;
    end else if (bus_wr && i_paddr == frie_pkg::FRIE_OFF_PC) begin
      pc_reg <= i_pwdata[frie_pkg::FRIE_PC_W-1:0];
    end
  end

  // Return stack
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sp_reg <= '0;
    end else if (exec_now && instr_reg.op == frie_pkg::FRIE_OP_CALL_ACC) begin
      sp_reg <= sp_reg + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (exec_now && instr_reg.op == frie_pkg::FRIE_OP_CALL_ACC) begin
      stack_mem[sp_reg] <= pc_reg + frie_pkg::FRIE_PC_ONE;
    end
  end

  // Skip marker
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      skip_reg <= 1'b0;
    end else if (exec_now) begin
      skip_reg <= instr_reg.op == frie_pkg::FRIE_OP_DEC_SKIP
        && result == frie_pkg::FRIE_DATA_ZERO;
    end
  end

  // Zero flag
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      zero_reg <= 1'b0;
    end else if (exec_now) begin
      unique case (instr_reg.op)
        frie_pkg::FRIE_OP_CLEAR_FILE,
        frie_pkg::FRIE_OP_CLEAR_ACC: zero_reg <= 1'b1;
        frie_pkg::FRIE_OP_COMPLEMENT,
        frie_pkg::FRIE_OP_DECREMENT:
          zero_reg <= (result == frie_pkg::FRIE_DATA_ZERO);
        default: zero_reg <= zero_reg;
      endcase
    end
  end

  // Watchdog counter and prescaler, free running
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      watchdog_counter_reg <= '0;
      presc_reg <= '0;
    end else if (exec_now && instr_reg.op == frie_pkg::FRIE_OP_WDT_CLEAR) begin
      watchdog_counter_reg <= '0;
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_reg + 1'b1;
      if (&presc_reg) begin
        watchdog_counter_reg <= watchdog_counter_reg + 1'b1;
      end
    end
  end

  // Power flags, cleared low by software writes of zero
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      timeout_n_reg <= 1'b1;
      sleep_n_reg <= 1'b1;
    end else if (exec_now && instr_reg.op == frie_pkg::FRIE_OP_WDT_CLEAR) begin
      timeout_n_reg <= 1'b1;
      sleep_n_reg <= 1'b1;
    end else if (bus_wr && i_paddr == frie_pkg::FRIE_OFF_STATUS) begin
      timeout_n_reg <= i_pwdata[frie_pkg::FRIE_ST_TIMEOUT_N_BIT];
      sleep_n_reg <= i_pwdata[frie_pkg::FRIE_ST_SLEEP_N_BIT];
    end
  end

  // APB read mux and ready, no wait state
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_reg <= frie_pkg::FRIE_BUS_ZERO;
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= bus_setup;
      if (bus_setup) begin
        rdata_reg <= frie_pkg::FRIE_BUS_ZERO;
        unique case (i_paddr)
          frie_pkg::FRIE_OFF_CTRL: rdata_reg[10:0] <=
            {instr_reg.op, instr_reg.dest_file, instr_reg.addr};
          frie_pkg::FRIE_OFF_ACC: rdata_reg[7:0] <= acc_reg;
          frie_pkg::FRIE_OFF_LATCH: rdata_reg[6:0] <= upper_pc_latch_reg;
          frie_pkg::FRIE_OFF_STATUS: rdata_reg[4:0] <= {skip_reg,
            state_reg != FRIE_ST_IDLE, timeout_n_reg, sleep_n_reg, zero_reg};
          frie_pkg::FRIE_OFF_PC: rdata_reg[14:0] <= pc_reg;
          frie_pkg::FRIE_OFF_FILE: rdata_reg[7:0] <= file_rd;
          frie_pkg::FRIE_OFF_WDT: rdata_reg[15:0] <= watchdog_counter_reg;
          frie_pkg::FRIE_OFF_STACK: rdata_reg[14:0] <= stack_top_entry;
          default: rdata_reg <= frie_pkg::FRIE_BUS_ZERO;
        endcase
      end
    end
  end

  // Registered outputs, slave error tied low
  assign o_prdata = rdata_reg;
  assign o_pready = ready_reg;
  assign o_pslverr = 1'b0;
  assign o_program_counter = pc_reg;
  assign o_timeout_flag_n = timeout_n_reg;
  assign o_sleep_flag_n = sleep_n_reg;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= go_write || (state_reg == FRIE_ST_EXEC
        && (instr_reg.op == frie_pkg::FRIE_OP_CALL_ACC
        || (instr_reg.op == frie_pkg::FRIE_OP_DEC_SKIP
        && result == frie_pkg::FRIE_DATA_ZERO)));
    end
  end

endmodule // frie_exec

/* tb/frie_exec_sva.sv */
// Port-level checker for the instruction executer
`timescale 1ns/1ps
module frie_exec_sva (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Core state
  input wire logic [frie_pkg::FRIE_PC_W-1:0] o_program_counter,
  input wire logic o_timeout_flag_n,
  input wire logic o_sleep_flag_n,
  input wire logic o_busy
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  logic wr_ok;
  logic go;
  logic one;
  logic [2:0] op;
  logic [7:0] acc_q;
  logic [6:0] latch_q;
  logic acc_ok;
  // Accepted writes and decoded start of an instruction
  assign wr_ok = i_psel && i_penable && o_pready && i_pwrite;
  assign op = i_pwdata[10:8];
  assign go = wr_ok && i_paddr == frie_pkg::FRIE_OFF_CTRL && i_pwdata[31]
    && !o_busy;
  assign one = go && op != 3'h0 && op != 3'h2 && op != 3'h7;
  // Shadow of accumulator and latch written by software
  always_ff @(posedge i_sys_clk) begin
    if (wr_ok && i_paddr == frie_pkg::FRIE_OFF_ACC) acc_q <= i_pwdata[7:0];
    if (wr_ok && i_paddr == frie_pkg::FRIE_OFF_LATCH) begin
      latch_q <= i_pwdata[6:0];
    end
  end
  // Shadow accumulator trusted only until an instruction may change it
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc_ok <= 1'b0;
    end else if (wr_ok && i_paddr == frie_pkg::FRIE_OFF_ACC) begin
      acc_ok <= 1'b1;
    end else if (go && (op == 3'h3 || op == 3'h5 || op[2:1] == 2'b11)) begin
      acc_ok <= 1'b0;
    end
  end
  a_pready_after: assert property (i_psel && !i_penable |=> o_pready)
    else $error("pready late");
  a_pready_once: assert property (o_pready |=> !o_pready)
    else $error("pready too long");
  a_slverr_low: assert property (!o_pslverr) else $error("slverr high");
  a_wdt_flags: assert property (go && op == 3'h1 |-> ##2
    (o_timeout_flag_n && o_sleep_flag_n)) else $error("flags not set");
  a_pc_step_one: assert property (one |-> ##2
    o_program_counter == $past(o_program_counter, 2) + 15'h0001)
    else $error("pc step");
  a_busy_single: assert property (one |-> ##1 o_busy ##1 !o_busy)
    else $error("single busy");
  a_busy_call: assert property (go && op == 3'h2 |-> ##1 o_busy[*2]
    ##1 !o_busy) else $error("call busy");
  a_call_target: assert property (go && op == 3'h2 && acc_ok |-> ##3
    o_program_counter == {latch_q, acc_q}) else $error("call target");
  a_call_flags: assert property (go && op == 3'h2 |-> ##1
    ($stable(o_timeout_flag_n) && $stable(o_sleep_flag_n))[*3])
    else $error("call flags");
endmodule // frie_exec_sva
bind frie_exec frie_exec_sva frie_exec_sva_i (.i_sys_clk, .i_arst_n, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
  .o_pslverr, .o_program_counter, .o_timeout_flag_n, .o_sleep_flag_n, .o_busy);

/* tb/tb_frie_exec.sv */
// Self-checking bench for the instruction executer
`timescale 1ns/1ps
module tb_frie_exec;
  logic i_sys_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic [frie_pkg::FRIE_PC_W-1:0] o_program_counter;
  logic [frie_pkg::FRIE_PC_W-1:0] pc0;
  logic o_timeout_flag_n;
  logic o_sleep_flag_n;
  logic o_busy;
  logic [31:0] rv;
  logic [31:0] junk;
  int err_count = 0;
  int checks = 0;
  // Clock
  always #5 i_sys_clk = ~i_sys_clk;
  frie_exec frie_exec_i (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_program_counter(o_program_counter),
    .o_timeout_flag_n(o_timeout_flag_n), .o_sleep_flag_n(o_sleep_flag_n),
    .o_busy(o_busy));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    @(posedge i_sys_clk);
    while (o_pready !== 1'b1 && n < 16) begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n >= 16) begin
      err_count++;
      $display("BAD %0t no pready", $time);
    end
    q = o_prdata;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, junk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0000_0000, q);
  endtask
  // Start one instruction and wait for it to finish
  task automatic run(input frie_pkg::frie_op_t op, input logic dst,
    input logic [6:0] a);
    int n;
    n = 0;
    wr(frie_pkg::FRIE_OFF_CTRL, {1'b1, 20'h0_0000, op, dst, a});
    repeat (2) @(posedge i_sys_clk);
    while (o_busy === 1'b1 && n < 10) begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n >= 10) begin
      err_count++;
      $display("BAD %0t busy stuck", $time);
    end
  endtask
  task automatic setf(input logic [6:0] a, input logic [7:0] d);
    wr(frie_pkg::FRIE_OFF_FILE, {17'h0_0000, a, d});
  endtask
  task automatic getf(input logic [6:0] a, output logic [31:0] q);
    // Go with no operation loads the read address
    wr(frie_pkg::FRIE_OFF_CTRL, {1'b1, 24'h00_0000, a});
    rd(frie_pkg::FRIE_OFF_FILE, q);
  endtask
  task automatic zflag(input logic z);
    rd(frie_pkg::FRIE_OFF_STATUS, rv);
    chk(rv[0], z);
  endtask
  // Complement to both destinations and zero result
  task automatic t_comp;
    setf(7'h05, 8'hA5);
    run(frie_pkg::FRIE_OP_COMPLEMENT, 1'b0, 7'h05);
    rd(frie_pkg::FRIE_OFF_ACC, rv);
    chk(rv[7:0], 8'h5A);
    getf(7'h05, rv);
    chk(rv[7:0], 8'hA5);
    zflag(1'b0);
    run(frie_pkg::FRIE_OP_COMPLEMENT, 1'b1, 7'h05);
    getf(7'h05, rv);
    chk(rv[7:0], 8'h5A);
    setf(7'h05, 8'hFF);
    run(frie_pkg::FRIE_OP_COMPLEMENT, 1'b1, 7'h05);
    getf(7'h05, rv);
    chk(rv[7:0], 8'h00);
    zflag(1'b1);
    $display("complement test done");
  endtask
  // Clear file at top address and clear accumulator
  task automatic t_clear;
    setf(7'h7F, 8'h44);
    run(frie_pkg::FRIE_OP_COMPLEMENT, 1'b0, 7'h7F);
    zflag(1'b0);
    run(frie_pkg::FRIE_OP_CLEAR_FILE, 1'b1, 7'h7F);
    getf(7'h7F, rv);
    chk(rv[7:0], 8'h00);
    zflag(1'b1);
    run(frie_pkg::FRIE_OP_COMPLEMENT, 1'b0, 7'h7F);
    run(frie_pkg::FRIE_OP_CLEAR_ACC, 1'b0, 7'h00);
    rd(frie_pkg::FRIE_OFF_ACC, rv);
    chk(rv[7:0], 8'h00);
    zflag(1'b1);
    $display("clear test done");
  endtask
  // Decrement with wrap and with zero result
  task automatic t_dec;
    setf(7'h00, 8'h00);
    run(frie_pkg::FRIE_OP_DECREMENT, 1'b1, 7'h00);
    getf(7'h00, rv);
    chk(rv[7:0], 8'hFF);
    zflag(1'b0);
    setf(7'h01, 8'h01);
    run(frie_pkg::FRIE_OP_DECREMENT, 1'b0, 7'h01);
    rd(frie_pkg::FRIE_OFF_ACC, rv);
    chk(rv[7:0], 8'h00);
    getf(7'h01, rv);
    chk(rv[7:0], 8'h01);
    zflag(1'b1);
    $display("decrement test done");
  endtask
  // Skip not taken, then taken, flags untouched
  task automatic t_skip;
    setf(7'h02, 8'h02);
    pc0 = o_program_counter;
    run(frie_pkg::FRIE_OP_DEC_SKIP, 1'b1, 7'h02);
    chk(o_program_counter, pc0 + 15'h0001);
    zflag(1'b1);
    chk(rv[frie_pkg::FRIE_ST_SKIP_BIT], 1'b0);
    getf(7'h02, rv);
    chk(rv[7:0], 8'h01);
    setf(7'h03, 8'h00);
    run(frie_pkg::FRIE_OP_COMPLEMENT, 1'b0, 7'h03);
    pc0 = o_program_counter;
    run(frie_pkg::FRIE_OP_DEC_SKIP, 1'b0, 7'h02);
    chk(o_program_counter, pc0 + 15'h0002);
    rd(frie_pkg::FRIE_OFF_ACC, rv);
    chk(rv[7:0], 8'h00);
    zflag(1'b0);
    chk(rv[frie_pkg::FRIE_ST_SKIP_BIT], 1'b1);
    $display("skip test done");
  endtask
  // Call through accumulator and latch
  task automatic t_call;
    wr(frie_pkg::FRIE_OFF_ACC, 32'h0000_0034);
    wr(frie_pkg::FRIE_OFF_LATCH, 32'h0000_0055);
    pc0 = o_program_counter;
    run(frie_pkg::FRIE_OP_CALL_ACC, 1'b0, 7'h00);
    chk(o_program_counter, 15'h5534);
    rd(frie_pkg::FRIE_OFF_STACK, rv);
    chk(rv[14:0], pc0 + 15'h0001);
    zflag(1'b0);
    $display("call test done");
  endtask
  // Watchdog clear restores flags and zeroes the count
  task automatic t_wdt;
    wr(frie_pkg::FRIE_OFF_STATUS, 32'h0000_0000);
    @(posedge i_sys_clk);
    chk({o_timeout_flag_n, o_sleep_flag_n}, 2'b00);
    run(frie_pkg::FRIE_OP_WDT_CLEAR, 1'b0, 7'h00);
    chk({o_timeout_flag_n, o_sleep_flag_n}, 2'b11);
    rd(frie_pkg::FRIE_OFF_WDT, rv);
    chk(rv, 32'h0000_0000);
    rd(12'h040, rv);
    chk(rv, 32'h0000_0000);
    $display("watchdog test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    err_count++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    @(posedge i_sys_clk);
    chk(o_program_counter, 15'h0000);
    chk({o_timeout_flag_n, o_sleep_flag_n}, 2'b11);
    t_comp();
    t_clear();
    t_dec();
    t_skip();
    t_call();
    t_wdt();
    tally_and_finish();
  end
endmodule // tb_frie_exec
